// File: shared/lcdc_defines.svh
// constants of the character display command decoder
`ifndef LCDC_DEFINES_SVH
`define LCDC_DEFINES_SVH

// ****************************************
// clock and link rates
// ****************************************
`define LCDC_CLK_HZ      25000000
`define LCDC_BAUD_0      2400
`define LCDC_BAUD_1      4800
`define LCDC_BAUD_2      9600
`define LCDC_BAUD_3      19200
`define LCDC_BAUD_4      28800
`define LCDC_BAUD_5      38400
`define LCDC_BAUD_6      57600
`define LCDC_BAUD_7      115200
`define LCDC_DIV_W       14

// ****************************************
// command bytes
// ****************************************
`define LCDC_ESC         8'h1B
`define LCDC_CMD_CLEAR   8'h43
`define LCDC_CMD_CSR_ON  8'h53
`define LCDC_CMD_CSR_OFF 8'h73
`define LCDC_CMD_BL_ON   8'h42
`define LCDC_CMD_BL_OFF  8'h62
`define LCDC_CMD_HOME    8'h48
`define LCDC_CMD_LOCATE  8'h4C
`define LCDC_CMD_DEFCHR  8'h44
`define LCDC_ROW1        8'h01
`define LCDC_ROW4        8'h04
`define LCDC_GLYPH_LO    8'h08
`define LCDC_GLYPH_HI    8'h0F
`define LCDC_GLYPH_ROWS  4'h8

// ****************************************
// reset values
// ****************************************
`define LCDC_RST_CSR     1'b1
`define LCDC_RST_BL      1'b1

`endif

// File: shared/lcdc_pkg.sv
// types shared by the character display command decoder
package lcdc_pkg;

    // decoder states
    typedef enum logic [2:0] {
        DEC_IDLE  = 3'h0,
        DEC_ESC   = 3'h1,
        DEC_LOC_X = 3'h2,
        DEC_LOC_Y = 3'h3,
        DEC_CODE  = 3'h4,
        DEC_BMP   = 3'h5
    } lcdc_dec_e;

    // i2c slave states
    typedef enum logic [2:0] {
        I2C_IDLE  = 3'h0,
        I2C_ADDR  = 3'h1,
        I2C_ACK_A = 3'h2,
        I2C_DATA  = 3'h3,
        I2C_ACK_D = 3'h4
    } lcdc_i2c_e;

    // one received byte
    typedef struct packed {
        logic       vld;
        logic [7:0] data;
    } lcdc_byte_s;

    // display actions
    typedef struct packed {
        logic       clear;
        logic       char_wr;
        logic [7:0] char_code;
        logic [7:0] col;
        logic [7:0] row;
        logic       cursor_on;
        logic       backlight_on;
    } lcdc_disp_s;

endpackage : lcdc_pkg

// File: verification/lcdc_ctrl_bench.sv
// self-checking bench of the display command decoder
`timescale 1ns/1ps

module lcdc_ctrl_bench;
    logic                 clock, arst_n, sda_out, sda_oe_n, ack;
    logic                 rx_line, scl_line, sda_low, sda_line;
    logic [3:0]           dip_sw;
    logic [15:0]          bit_cycles;
    logic [2:0]           glyph_code, glyph_row;
    logic [7:0]           glyph_bits, last_char;
    lcdc_pkg::lcdc_disp_s disp;
    int                   fail_count, cmp_count, char_count, clear_count;
    logic [7:0]           tog_cmd [4] = '{8'h73, 8'h53, 8'h62, 8'h42};
    logic [1:0]           tog_exp [4] = '{2'b01, 2'b11, 2'b10, 2'b11};

    // wired-and sda with pull-up
    assign sda_line = ~sda_low & (sda_oe_n | sda_out);

    lcdc_ctrl #(.BAUD_DIV_0(16), .BAUD_DIV_1(8)) dut_u (
        .clock(clock), .arst_n(arst_n), .dip_sw(dip_sw),
        .scl_in(scl_line), .sda_in(sda_line), .sda_out(sda_out),
        .sda_oe_n(sda_oe_n), .rx_in(rx_line), .disp(disp),
        .glyph_code(glyph_code), .glyph_row(glyph_row),
        .glyph_bits(glyph_bits));

    lcdc_host host_u (
        .clock(clock), .bit_cycles(bit_cycles), .rx_line(rx_line),
        .scl_line(scl_line), .sda_low(sda_low), .sda_line(sda_line));

    // clock
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    // count display pulses
    always @(negedge clock) begin
        if (disp.char_wr === 1'b1) begin
            char_count++;
            last_char = disp.char_code;
        end
        if (disp.clear === 1'b1) clear_count++;
    end

    // ****
    // tasks
    // ****
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: seen %0h expected %0h",
                     $time, seen, exp);
        end
    endtask : check

    task automatic send(input logic [7:0] b);
        host_u.uart_send(b);
        repeat (4) @(negedge clock);
    endtask : send

    task automatic send_cmd(input logic [7:0] c);
        send(8'h1B);
        send(c);
    endtask : send_cmd

    task automatic glyph_def(input logic [7:0] code, input logic [7:0] base);
        send_cmd(8'h44);
        send(code);
        for (int r = 0; r < 8; r++) send(base + 8'(r));
    endtask : glyph_def

    task automatic end_sim();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : end_sim

    // watchdog
    initial begin
        repeat (60000) @(posedge clock);
        fail_count++;
        end_sim();
    end

    // ****
    // tests
    // ****
    initial begin
        arst_n = 1'b0;
        dip_sw = 4'h0;
        bit_cycles = 16'd16;
        glyph_code = 3'h0;
        glyph_row = 3'h0;
        repeat (10) @(negedge clock);
        arst_n = 1'b1;
        repeat (4) @(negedge clock);
        check(disp.cursor_on, 1'b1);
        check(disp.backlight_on, 1'b1);
        check(sda_oe_n, 1'b1);
        send(8'h41);
        check(last_char, 8'h41);
        check({disp.col, disp.row}, 16'h0100);
        for (int i = 0; i < 4; i++) begin
            send_cmd(tog_cmd[i]);
            check({disp.cursor_on, disp.backlight_on}, tog_exp[i]);
        end
        send_cmd(8'h4C);
        send(8'h05);
        send(8'h02);
        check({disp.col, disp.row}, 16'h0502);
        send_cmd(8'h48);
        check({disp.col, disp.row}, 16'h0000);
        check(16'(char_count), 16'h0001);
        for (int i = 1; i <= 4; i++) begin
            send(8'h41);
            send(8'(i));
            check({disp.col, disp.row}, 16'(i - 1));
        end
        send_cmd(8'h7A);
        check(16'(char_count), 16'h0005);
        send(8'h62);
        check(last_char, 8'h62);
        check(disp.backlight_on, 1'b1);
        send_cmd(8'h43);
        check(16'(clear_count), 16'h0001);
        check({disp.col, disp.row}, 16'h0000);
        glyph_def(8'h0A, 8'hA0);
        glyph_def(8'h08, 8'h30);
        glyph_def(8'h0F, 8'hF0);
        glyph_def(8'h07, 8'h50);
        check(16'(char_count), 16'h0006);
        for (int r = 0; r < 8; r++) begin
            glyph_code = 3'h2;
            glyph_row = 3'(r);
            repeat (2) @(negedge clock);
            check(glyph_bits, 8'hA0 + 8'(r));
        end
        glyph_code = 3'h0;
        repeat (2) @(negedge clock);
        check(glyph_bits, 8'h37);
        glyph_code = 3'h7;
        repeat (2) @(negedge clock);
        check(glyph_bits, 8'hF7);
        send(8'h0A);
        check(last_char, 8'h0A);
        // switch setting 1, top bit set; one link at a time
        dip_sw = 4'h9;
        bit_cycles = 16'd8;
        repeat (4) @(negedge clock);
        send(8'h43);
        check(last_char, 8'h43);
        host_u.i2c_start();
        host_u.i2c_put(8'h02, ack);
        check(ack, 1'b1);
        host_u.i2c_put(8'h5A, ack);
        check(ack, 1'b1);
        check(last_char, 8'h5A);
        host_u.i2c_put(8'h1B, ack);
        host_u.i2c_put(8'h73, ack);
        check(disp.cursor_on, 1'b0);
        host_u.i2c_stop();
        host_u.i2c_start();
        host_u.i2c_put(8'h04, ack);
        check(ack, 1'b0);
        host_u.i2c_put(8'h5B, ack);
        host_u.i2c_stop();
        check(last_char, 8'h5A);
        end_sim();
    end
endmodule : lcdc_ctrl_bench

// File: verification/lcdc_host.sv
// host side model: serial transmitter and i2c write master
`timescale 1ns/1ps

module lcdc_host #(
    parameter int HALF_SCL   = 8,
    parameter int CLEAR_WAIT = 300
) (
    // clock
    input  wire logic        clock,
    // serial bit period in clock cycles
    input  wire logic [15:0] bit_cycles,
    // serial pin
    output logic             rx_line,
    // i2c pins, sda pulled low when sda_low is set
    output logic             scl_line,
    output logic             sda_low,
    input  wire logic        sda_line
);
    logic [7:0] prev_q;

    // ****
    // serial transmit
    // ****
    task automatic uart_send(input logic [7:0] b);
        logic [9:0] frame;
        frame = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rx_line = frame[i];
            repeat (bit_cycles) @(negedge clock);
        end
        // settle time after a clear sequence
        if (prev_q == 8'h1B && b == 8'h43) begin
            repeat (CLEAR_WAIT) @(negedge clock);
        end
        prev_q = b;
    endtask : uart_send

    // ****
    // i2c master
    // ****
    task automatic half();
        repeat (HALF_SCL) @(negedge clock);
    endtask : half

    task automatic i2c_start();
        sda_low = 1'b1;
        half();
        scl_line = 1'b0;
        repeat (2) @(negedge clock);
    endtask : i2c_start

    task automatic i2c_put(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin // msb first
            sda_low = ~b[i];
            half();
            scl_line = 1'b1;
            half();
            scl_line = 1'b0;
            repeat (2) @(negedge clock);
        end
        sda_low = 1'b0; // release for the ack bit
        half();
        scl_line = 1'b1;
        ack = ~sda_line;
        half();
        scl_line = 1'b0;
        repeat (2) @(negedge clock);
    endtask : i2c_put

    task automatic i2c_stop();
        sda_low = 1'b1;
        half();
        scl_line = 1'b1;
        half();
        sda_low = 1'b0;
        half();
    endtask : i2c_stop

    // idle lines from time zero
    initial begin
        rx_line  = 1'b1;
        scl_line = 1'b1;
        sda_low  = 1'b0;
        prev_q   = 8'h00;
    end
endmodule : lcdc_host

// File: verilog/lcdc_ctrl.sv
// control logic of the serial character display
//
// How it works
// - i2c slave and serial receiver both feed one command decoder
// - switch bits 2:0 give slave address and baud rate 2400..115200
// - switch bit 3 is ignored
// - escape then 0x43 clears the screen
// - escape 0x4C, column, row moves cursor
// - escape 0x44, code 8-15, eight bitmap bytes store a glyph
// - bytes 0x01..0x04 move cursor to start of rows 1..4
// - every other byte is written as a character at the cursor
`timescale 1ns/1ps
`include "lcdc_defines.svh"

module lcdc_ctrl #(
    parameter int BAUD_DIV_0 = `LCDC_CLK_HZ / `LCDC_BAUD_0,
    parameter int BAUD_DIV_1 = `LCDC_CLK_HZ / `LCDC_BAUD_1
) (
    // clock and reset
    input  wire logic           clock,
    input  wire logic           arst_n,
    // configuration switch
    input  wire logic [3:0]     dip_sw,
    // i2c pins, open drain
    input  wire logic           scl_in,
    input  wire logic           sda_in,
    output logic                sda_out,
    output logic                sda_oe_n,
    // serial pin
    input  wire logic           rx_in,
    // display actions
    output lcdc_pkg::lcdc_disp_s disp,
    // glyph lookup
    input  wire logic [2:0]     glyph_code,
    input  wire logic [2:0]     glyph_row,
    output logic [7:0]          glyph_bits
);

    // ****************************************
    // baud selection
    // ****************************************
    logic [`LCDC_DIV_W-1:0] baud_div;
    lcdc_pkg::lcdc_byte_s   uart_byte;
    logic [2:0]             dip_s1_q;
    logic [2:0]             dip_s2_q;

    // switch is a pin: two flops before any logic reads it
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            dip_s1_q <= 3'h0;
            dip_s2_q <= 3'h0;
        end else begin
            dip_s1_q <= dip_sw[2:0];
            dip_s2_q <= dip_s1_q;
        end
    end

    // bit 3 of the switch plays no part
    always_comb begin
        unique case (dip_s2_q)
            3'h0: baud_div = `LCDC_DIV_W'(BAUD_DIV_0);
            3'h1: baud_div = `LCDC_DIV_W'(BAUD_DIV_1);
            3'h2: baud_div = `LCDC_DIV_W'(`LCDC_CLK_HZ / `LCDC_BAUD_2);
            3'h3: baud_div = `LCDC_DIV_W'(`LCDC_CLK_HZ / `LCDC_BAUD_3);
            3'h4: baud_div = `LCDC_DIV_W'(`LCDC_CLK_HZ / `LCDC_BAUD_4);
            3'h5: baud_div = `LCDC_DIV_W'(`LCDC_CLK_HZ / `LCDC_BAUD_5);
            3'h6: baud_div = `LCDC_DIV_W'(`LCDC_CLK_HZ / `LCDC_BAUD_6);
            3'h7: baud_div = `LCDC_DIV_W'(`LCDC_CLK_HZ / `LCDC_BAUD_7);
        endcase
    end

    // serial receiver
    lcdc_uart_rx u_rx (
        .clock    (clock),
        .arst_n   (arst_n),
        .baud_div (baud_div),
        .rx_in    (rx_in),
        .rx_byte  (uart_byte)
    );

    // ****************************************
    // i2c slave, write only
    // ****************************************
    logic [1:0]          scl_sy_q;
    logic [1:0]          sda_sy_q;
    logic                scl_p_q;
    logic                sda_p_q;
    lcdc_pkg::lcdc_i2c_e i2c_q;
    logic [3:0]          i2c_cnt_q;
    logic [7:0]          i2c_sh_q;
    logic                oe_n_q;
    lcdc_pkg::lcdc_byte_s i2c_byte_q;
    logic                scl_rise;
    logic                scl_fall;
    logic                i2c_start;
    logic                i2c_stop;

    // synchronisers plus one delay for edges
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            scl_sy_q <= 2'h3;
            sda_sy_q <= 2'h3;
            scl_p_q  <= 1'b1;
            sda_p_q  <= 1'b1;
        end else begin
            scl_sy_q <= {scl_sy_q[0], scl_in};
            sda_sy_q <= {sda_sy_q[0], sda_in};
            scl_p_q  <= scl_sy_q[1];
            sda_p_q  <= sda_sy_q[1];
        end
    end

    // bus conditions
    assign scl_rise  = scl_sy_q[1] & ~scl_p_q;
    assign scl_fall  = ~scl_sy_q[1] & scl_p_q;
    assign i2c_start = scl_sy_q[1] & scl_p_q & sda_p_q & ~sda_sy_q[1];
    assign i2c_stop  = scl_sy_q[1] & scl_p_q & ~sda_p_q & sda_sy_q[1];

    // slave sequencer, acks only its own address
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            i2c_q      <= lcdc_pkg::I2C_IDLE;
            i2c_cnt_q  <= 4'h0;
            i2c_sh_q   <= 8'h00;
            oe_n_q     <= 1'b1;
            i2c_byte_q <= '0;
        end else begin
            i2c_byte_q.vld <= 1'b0;
            if (i2c_start) begin
                i2c_q     <= lcdc_pkg::I2C_ADDR;
                i2c_cnt_q <= 4'h0;
                oe_n_q    <= 1'b1;
            end else if (i2c_stop) begin
                i2c_q  <= lcdc_pkg::I2C_IDLE;
                oe_n_q <= 1'b1;
            end else if (scl_rise && (i2c_q == lcdc_pkg::I2C_ADDR ||
                                      i2c_q == lcdc_pkg::I2C_DATA)) begin
                i2c_sh_q  <= {i2c_sh_q[6:0], sda_sy_q[1]};
                i2c_cnt_q <= i2c_cnt_q + 4'h1;
            end else if (scl_fall) begin
                unique case (i2c_q)
                    lcdc_pkg::I2C_IDLE: ;
                    lcdc_pkg::I2C_ADDR: begin
                        if (i2c_cnt_q == 4'h8) begin
                            if (i2c_sh_q == {4'h0, dip_s2_q, 1'b0}) begin
                                i2c_q  <= lcdc_pkg::I2C_ACK_A;
                                oe_n_q <= 1'b0;
                            end else begin
                                i2c_q <= lcdc_pkg::I2C_IDLE;
                            end
                        end
                    end
                    lcdc_pkg::I2C_DATA: begin
                        if (i2c_cnt_q == 4'h8) begin
                            i2c_q           <= lcdc_pkg::I2C_ACK_D;
                            oe_n_q          <= 1'b0;
                            i2c_byte_q.vld  <= 1'b1;
                            i2c_byte_q.data <= i2c_sh_q;
                        end
                    end
                    lcdc_pkg::I2C_ACK_A,
                    lcdc_pkg::I2C_ACK_D: begin
                        i2c_q     <= lcdc_pkg::I2C_DATA;
                        i2c_cnt_q <= 4'h0;
                        oe_n_q    <= 1'b1;
                    end
                    default: i2c_q <= lcdc_pkg::I2C_IDLE;
                endcase
            end
        end
    end

    assign sda_out  = 1'b0;
    assign sda_oe_n = oe_n_q;

    // ****************************************
    // command decoder
    // ****************************************
    lcdc_pkg::lcdc_byte_s in_b;
    lcdc_pkg::lcdc_dec_e  dec_q;
    lcdc_pkg::lcdc_disp_s disp_q;
    logic [7:0]           code_q;
    logic [3:0]           bmp_q;
    logic [7:0]           glyph_mem [0:63];

    // both links share the decoder, i2c wins on a clash and the serial byte is lost
    assign in_b = i2c_byte_q.vld ? i2c_byte_q : uart_byte;

    // sequence state and display state
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            dec_q               <= lcdc_pkg::DEC_IDLE;
            code_q              <= 8'h00;
            bmp_q               <= 4'h0;
            disp_q              <= '0;
            disp_q.cursor_on    <= `LCDC_RST_CSR;
            disp_q.backlight_on <= `LCDC_RST_BL;
        end else begin
            disp_q.clear   <= 1'b0;
            disp_q.char_wr <= 1'b0;
            if (in_b.vld) begin
                unique case (dec_q)
                    lcdc_pkg::DEC_IDLE: begin
                        if (in_b.data == `LCDC_ESC) begin
                            dec_q <= lcdc_pkg::DEC_ESC;
                        end else if (in_b.data >= `LCDC_ROW1 &&
                                     in_b.data <= `LCDC_ROW4) begin
                            disp_q.col <= 8'h00;
                            disp_q.row <= in_b.data - `LCDC_ROW1;
                        end else begin
                            disp_q.char_wr   <= 1'b1;
                            disp_q.char_code <= in_b.data;
                            disp_q.col       <= disp_q.col + 8'h01;
                        end
                    end
                    lcdc_pkg::DEC_ESC: begin
                        dec_q <= lcdc_pkg::DEC_IDLE;
                        unique case (in_b.data)
                            `LCDC_CMD_CLEAR: begin
                                disp_q.clear <= 1'b1;
                                disp_q.col   <= 8'h00;
                                disp_q.row   <= 8'h00;
                            end
                            `LCDC_CMD_CSR_ON:  disp_q.cursor_on <= 1'b1;
                            `LCDC_CMD_CSR_OFF: disp_q.cursor_on <= 1'b0;
                            `LCDC_CMD_BL_ON:   disp_q.backlight_on <= 1'b1;
                            `LCDC_CMD_BL_OFF:  disp_q.backlight_on <= 1'b0;
                            `LCDC_CMD_HOME: begin
                                disp_q.col <= 8'h00;
                                disp_q.row <= 8'h00;
                            end
                            `LCDC_CMD_LOCATE: dec_q <= lcdc_pkg::DEC_LOC_X;
                            `LCDC_CMD_DEFCHR: dec_q <= lcdc_pkg::DEC_CODE;
                            default: ;
                        endcase
                    end
                    lcdc_pkg::DEC_LOC_X: begin
                        code_q <= in_b.data;
                        dec_q  <= lcdc_pkg::DEC_LOC_Y;
                    end
                    lcdc_pkg::DEC_LOC_Y: begin
                        disp_q.col <= code_q;
                        disp_q.row <= in_b.data;
                        dec_q      <= lcdc_pkg::DEC_IDLE;
                    end
                    lcdc_pkg::DEC_CODE: begin
                        code_q <= in_b.data;
                        bmp_q  <= 4'h0;
                        dec_q  <= lcdc_pkg::DEC_BMP;
                    end
                    lcdc_pkg::DEC_BMP: begin
                        bmp_q <= bmp_q + 4'h1;
                        if (bmp_q == `LCDC_GLYPH_ROWS - 4'h1) begin
                            dec_q <= lcdc_pkg::DEC_IDLE;
                        end
                    end
                    default: dec_q <= lcdc_pkg::DEC_IDLE;
                endcase
            end
        end
    end

    // glyph store, codes outside 8..15 swallow their bytes
    logic glyph_we;
    assign glyph_we = in_b.vld && dec_q == lcdc_pkg::DEC_BMP &&
                      code_q >= `LCDC_GLYPH_LO && code_q <= `LCDC_GLYPH_HI;

    always_ff @(posedge clock) begin
        if (glyph_we) begin
            glyph_mem[{code_q[2:0], bmp_q[2:0]}] <= in_b.data;
        end
        glyph_bits <= glyph_mem[{glyph_code, glyph_row}];
    end

    assign disp = disp_q;

    // ****************************************
    // assertions
    // ****************************************
    sequence esc_cmd(logic [7:0] c);
        in_b.vld && dec_q == lcdc_pkg::DEC_ESC && in_b.data == c;
    endsequence

    // row byte of a locate arrives, column already held
    sequence loc_done;
        in_b.vld && dec_q == lcdc_pkg::DEC_LOC_Y;
    endsequence

    screen_clear_a: assert property (@(posedge clock) disable iff (!arst_n)
        esc_cmd(`LCDC_CMD_CLEAR) |=> disp.clear && disp.col == 8'h00
        ##1 !disp.clear)
        else $error("clear pulse missing");

    cursor_off_a: assert property (@(posedge clock) disable iff (!arst_n)
        esc_cmd(`LCDC_CMD_CSR_OFF) |=> !disp.cursor_on)
        else $error("cursor not off");

    light_on_a: assert property (@(posedge clock) disable iff (!arst_n)
        esc_cmd(`LCDC_CMD_BL_ON) |=> disp.backlight_on)
        else $error("backlight not on");

    cursor_home_a: assert property (@(posedge clock) disable iff (!arst_n)
        esc_cmd(`LCDC_CMD_HOME) |=> disp.col == 8'h00 && disp.row == 8'h00)
        else $error("home failed");

    locate_pos_a: assert property (@(posedge clock) disable iff (!arst_n)
        loc_done |=> disp.col == $past(code_q) &&
                     disp.row == $past(in_b.data))
        else $error("locate wrong");

    row_start_a: assert property (@(posedge clock) disable iff (!arst_n)
        in_b.vld && dec_q == lcdc_pkg::DEC_IDLE && in_b.data == 8'h03
        |=> disp.row == 8'h02 && disp.col == 8'h00 && !disp.char_wr)
        else $error("row start wrong");

    char_write_a: assert property (@(posedge clock) disable iff (!arst_n)
        in_b.vld && dec_q == lcdc_pkg::DEC_IDLE && in_b.data > `LCDC_ROW4 &&
        in_b.data != `LCDC_ESC |=> disp.char_wr &&
        disp.char_code == $past(in_b.data))
        else $error("char not written");

    esc_unknown_a: assert property (@(posedge clock) disable iff (!arst_n)
        esc_cmd(8'h7A) |=> !disp.char_wr && dec_q == lcdc_pkg::DEC_IDLE)
        else $error("unknown escape not dropped");

    glyph_range_a: assert property (@(posedge clock) disable iff (!arst_n)
        glyph_we |-> code_q[7:3] == 5'h01 && bmp_q < 4'h8)
        else $error("glyph write out of range");

    addr_ack_a: assert property (@(posedge clock) disable iff (!arst_n)
        i2c_q == lcdc_pkg::I2C_ACK_A && $fell(oe_n_q)
        |-> $past(i2c_sh_q[7:1]) == {4'h0, dip_s2_q})
        else $error("ack to foreign address");

endmodule : lcdc_ctrl

// File: verilog/lcdc_uart_rx.sv
// serial receiver, 8 data bits, no parity, one stop bit
`timescale 1ns/1ps
`include "lcdc_defines.svh"

module lcdc_uart_rx (
    // clock and reset
    input  wire logic                   clock,
    input  wire logic                   arst_n,
    // bit period in clock cycles
    input  wire logic [`LCDC_DIV_W-1:0] baud_div,
    // serial pin
    input  wire logic                   rx_in,
    // received byte
    output lcdc_pkg::lcdc_byte_s        rx_byte
);

    logic                   sync1_q;
    logic                   sync2_q;
    logic                   busy_q;
    logic [`LCDC_DIV_W-1:0] cnt_q;
    logic [3:0]             bit_q;
    logic [7:0]             sh_q;
    lcdc_pkg::lcdc_byte_s   out_q;

    // two-stage synchroniser on the pin
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            sync1_q <= 1'b1;
            sync2_q <= 1'b1;
        end else begin
            sync1_q <= rx_in;
            sync2_q <= sync1_q;
        end
    end

    // frame sampling at mid bit
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            busy_q <= 1'b0;
            cnt_q  <= '0;
            bit_q  <= 4'h0;
            sh_q   <= 8'h00;
            out_q  <= '0;
        end else begin
            out_q.vld <= 1'b0;
            if (!busy_q) begin
                if (!sync2_q) begin
                    busy_q <= 1'b1;
                    cnt_q  <= baud_div >> 1;
                    bit_q  <= 4'h0;
                end
            end else if (cnt_q != '0) begin
                cnt_q <= cnt_q - 1'b1;
            end else begin
                cnt_q <= baud_div - 1'b1;
                bit_q <= bit_q + 4'h1;
                if (bit_q == 4'h0 && sync2_q) begin
                    busy_q <= 1'b0;        // false start
                end else if (bit_q == 4'h9) begin
                    busy_q <= 1'b0;
                    if (sync2_q) begin     // good stop bit
                        out_q.vld  <= 1'b1;
                        out_q.data <= sh_q;
                    end
                end else if (bit_q != 4'h0) begin
                    sh_q <= {sync2_q, sh_q[7:1]};
                end
            end
        end
    end

    assign rx_byte = out_q;

endmodule : lcdc_uart_rx
